/* File: eeprom_link_consts.svh */
`ifndef EEPROM_LINK_CONSTS_SVH
`define EEPROM_LINK_CONSTS_SVH

// Memory seen from the serial side
`define EE_MEM_BYTES 8192
`define EE_ADDR_W 13
// Device type identifier, value arbitrary
`define EE_TYPE_ID 4'h6
// Low select bits sent by the master: chip bit and two fixed ones
`define EE_SEL_LOW 3'h3
`define EE_BUF_DEPTH 2
// System clock and timing
`define EE_CLK_PERIOD_NS 5
`define EE_RF_OFF_MIN_TIME_NS 500
`define EE_RF_OFF_MIN_CYCLES ((`EE_RF_OFF_MIN_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)
// Serial clock quarter period made by the master
`define EE_SCL_QUARTER_NS 625
`define EE_SCL_QUARTER_CYCLES (`EE_SCL_QUARTER_NS / `EE_CLK_PERIOD_NS)

`endif

/* File: eeprom_link_pkg.sv */
package eeprom_link_pkg;

	typedef enum logic [7:0] {
		d_idle  = 8'h01,
		d_sel   = 8'h02,
		d_ahi   = 8'h04,
		d_alo   = 8'h08,
		d_wdata = 8'h10,
		d_rdata = 8'h20
	} dev_state_t;

	typedef enum logic [3:0] {
		op_start = 4'h1,
		op_tx    = 4'h2,
		op_rx    = 4'h4,
		op_stop  = 4'h8
	} host_op_t;

	typedef enum logic [1:0] {
		h_idle = 2'h1,
		h_run  = 2'h2
	} host_state_t;

	typedef enum logic {
		rf_write_indication_mode   = 1'b0,
		rf_command_indication_mode = 1'b1
	} rf_ind_mode_t;

endpackage : eeprom_link_pkg

/* File: i2c_link_if.sv */
`timescale 1ns/10ps
interface i2c_link_if;
	logic scl_line;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda_line;
	logic rf_activity_out;
	logic rf_activity_oe;
	logic rf_activity_line;

	// Open-drain wires with pull-ups
	assign sda_line = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
	assign rf_activity_line = !(rf_activity_oe && !rf_activity_out);

	modport device (
		input  scl_line,
		input  sda_line,
		output sda_dev_out,
		output sda_dev_oe,
		output rf_activity_out,
		output rf_activity_oe
	);

	modport host (
		output scl_line,
		input  sda_line,
		output sda_host_out,
		output sda_host_oe,
		input  rf_activity_line
	);
endinterface : i2c_link_if

/* File: two_entry_buffer.sv */
`timescale 1ns/10ps
`include "eeprom_link_consts.svh"
module two_entry_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `EE_BUF_DEPTH
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	output wire logic             in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output wire logic             out_valid_out,
	input  wire logic             out_ready_in,
	output wire logic [WIDTH-1:0] out_data_out
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;

	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;

	assign in_ready_out = (count_reg != FULL);
	assign out_valid_out = (count_reg != '0);
	assign out_data_out = store_reg[rd_ptr_reg];

	always_ff @(posedge clk_sys_in)
	begin
		if (push)
			store_reg[wr_ptr_reg] <= in_data_in;
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule : two_entry_buffer

/* File: eeprom_device_end.sv */
// Functional notes
// - Slave only, stepped by external serial clock
// - Master opens every transfer with Start
// - Select code follows Start, device acknowledges it
// - Device acknowledges each written byte the buffer accepts, ninth bit
// - Master acknowledges each byte it reads except the last, which gets NoAck
// - Stop after Ack on write, NoAck on read
// - Respond only when upper four bits match type
// - Serial clock is input only
// - Data line driven open-drain only
// - Write mode: pin low during RF write
// - Command mode: pin low during RF command
// - Activity pin open-drain, released when idle
// - Activity shown only when supply pin powered
// - Field off long enough resets RF logic
// - Harvest output off when disabled or weak field
// - Serial side sees 8192 byte locations
`timescale 1ns/10ps
`include "eeprom_link_consts.svh"
module eeprom_device_end #(
	parameter int         MEM_BYTES     = `EE_MEM_BYTES,
	parameter logic [3:0] TYPE_ID       = `EE_TYPE_ID,
	parameter int         RF_OFF_CYCLES = `EE_RF_OFF_MIN_CYCLES
) (
	input  wire logic     clk_sys_in,
	input  wire logic     rst_in,
	i2c_link_if.device    bus,
	input  wire logic     cfg_wr_in,
	input  wire logic     cfg_cmd_mode_in,
	input  wire logic     vcc_powered_in,
	input  wire logic     rf_write_busy_in,
	input  wire logic     rf_cmd_busy_in,
	input  wire logic     rf_field_off_in,
	input  wire logic     eh_enable_in,
	input  wire logic     rf_field_ok_in,
	output wire logic     rf_reset_out,
	output wire logic     eh_vout_enable_out,
	output wire logic     rf_command_indication_mode_out
);
	localparam int AW = `EE_ADDR_W;
	localparam int OFF_W = $clog2(RF_OFF_CYCLES + 1);
	localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(RF_OFF_CYCLES);

	logic                        scl_s1_reg;
	logic                        scl_s2_reg;
	logic                        scl_s3_reg;
	logic                        sda_s1_reg;
	logic                        sda_s2_reg;
	logic                        sda_s3_reg;
	eeprom_link_pkg::dev_state_t state_reg;
	eeprom_link_pkg::dev_state_t state_next;
	logic [3:0]                  bit_cnt_reg;
	logic [7:0]                  shift_reg;
	logic [7:0]                  out_reg;
	logic [AW-1:0]               addr_reg;
	logic                        rw_reg;
	logic                        mack_reg;
	logic                        drive_reg;
	logic                        drive_next;
	logic [7:0]                  mem [MEM_BYTES];
	logic                        mode_reg;
	logic                        act_oe_reg;
	logic [OFF_W-1:0]            off_cnt_reg;
	logic                        rf_reset_reg;
	logic                        eh_reg;
	logic                        buf_in_ready;
	logic                        buf_out_valid;
	logic [AW+7:0]               buf_out_data;
	logic                        ack_now;

	// Line synchronisers
	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_s3_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_s3_reg <= 1'b1;
		end
		else
		begin
			scl_s1_reg <= bus.scl_line;
			scl_s2_reg <= scl_s1_reg;
			scl_s3_reg <= scl_s2_reg;
			sda_s1_reg <= bus.sda_line;
			sda_s2_reg <= sda_s1_reg;
			sda_s3_reg <= sda_s2_reg;
		end
	end

	// Bus events, all timed by the system clock
	wire scl_rise = scl_s2_reg && !scl_s3_reg;
	wire scl_fall = !scl_s2_reg && scl_s3_reg;
	wire scl_high = scl_s2_reg && scl_s3_reg;
	wire start_det = scl_high && sda_s3_reg && !sda_s2_reg;
	wire stop_det = scl_high && !sda_s3_reg && sda_s2_reg;
	wire active = (state_reg != eeprom_link_pkg::d_idle);
	wire rx_state = active && (state_reg != eeprom_link_pkg::d_rdata);
	wire in_rdata = (state_reg == eeprom_link_pkg::d_rdata);
	wire in_sel = (state_reg == eeprom_link_pkg::d_sel);
	wire in_wdata = (state_reg == eeprom_link_pkg::d_wdata);
	wire byte_done = scl_fall && active && (bit_cnt_reg == 4'h7);
	wire ack_end = scl_fall && active && (bit_cnt_reg == 4'h8);
	wire sel_match = (shift_reg[7:4] == TYPE_ID);
	wire buf_push = byte_done && in_wdata && buf_in_ready;
	wire load_rd = ack_end && ((in_sel && rw_reg && drive_reg) || (in_rdata && mack_reg));
	wire [7:0] mem_rd = mem[addr_reg];

	always_comb
	begin
		case (state_reg)
			eeprom_link_pkg::d_sel:   ack_now = sel_match;
			eeprom_link_pkg::d_ahi:   ack_now = 1'b1;
			eeprom_link_pkg::d_alo:   ack_now = 1'b1;
			eeprom_link_pkg::d_wdata: ack_now = buf_in_ready;
			default:                  ack_now = 1'b0;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		if (start_det)
			state_next = eeprom_link_pkg::d_sel;
		else if (stop_det)
			state_next = eeprom_link_pkg::d_idle;
		else if (byte_done && in_sel && !sel_match)
			state_next = eeprom_link_pkg::d_idle;
		else if (ack_end)
		begin
			case (state_reg)
				eeprom_link_pkg::d_sel:
					state_next = rw_reg ? eeprom_link_pkg::d_rdata : eeprom_link_pkg::d_ahi;
				eeprom_link_pkg::d_ahi:
					state_next = eeprom_link_pkg::d_alo;
				eeprom_link_pkg::d_alo:
					state_next = eeprom_link_pkg::d_wdata;
				eeprom_link_pkg::d_wdata:
					state_next = drive_reg ? eeprom_link_pkg::d_wdata : eeprom_link_pkg::d_idle;
				eeprom_link_pkg::d_rdata:
					state_next = mack_reg ? eeprom_link_pkg::d_rdata : eeprom_link_pkg::d_idle;
				default:
					state_next = state_reg;
			endcase
		end
	end

	// Data line: only pull low or release
	always_comb
	begin
		drive_next = drive_reg;
		if (start_det || stop_det)
			drive_next = 1'b0;
		else if (byte_done)
			drive_next = rx_state && ack_now;
		else if (load_rd)
			drive_next = !mem_rd[7];
		else if (ack_end)
			drive_next = 1'b0;
		else if (scl_fall && in_rdata && (bit_cnt_reg < 4'h7))
			drive_next = !out_reg[6];
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			state_reg <= eeprom_link_pkg::d_idle;
			drive_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
		end
		else
		begin
			state_reg <= state_next;
			drive_reg <= drive_next;
			// Start's own clock fall must not count as a bit
			if (start_det)
				bit_cnt_reg <= 4'hf;
			else if (scl_fall && active)
				bit_cnt_reg <= (bit_cnt_reg == 4'h8) ? 4'h0 : bit_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
		end
		else
		begin
			if (scl_rise && rx_state && (bit_cnt_reg < 4'h8))
				shift_reg <= {shift_reg[6:0], sda_s2_reg};
			if (byte_done && in_sel)
				rw_reg <= shift_reg[0];
			if (scl_rise && in_rdata && (bit_cnt_reg == 4'h8))
				mack_reg <= !sda_s2_reg;
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			addr_reg <= '0;
			out_reg <= 8'h00;
		end
		else
		begin
			if (byte_done && (state_reg == eeprom_link_pkg::d_ahi))
				addr_reg[AW-1:8] <= shift_reg[AW-9:0];
			else if (byte_done && (state_reg == eeprom_link_pkg::d_alo))
				addr_reg[7:0] <= shift_reg;
			else if (buf_push || load_rd)
				addr_reg <= addr_reg + 1'b1;
			if (load_rd)
				out_reg <= mem_rd;
			else if (scl_fall && in_rdata && (bit_cnt_reg < 4'h7))
				out_reg <= {out_reg[6:0], 1'b0};
		end
	end

	assign bus.sda_dev_out = 1'b0;
	assign bus.sda_dev_oe = drive_reg;

	// Written bytes wait here while an RF write holds the array
	two_entry_buffer #(
		.WIDTH (AW + 8),
		.DEPTH (`EE_BUF_DEPTH)
	) write_buf (
		.clk_sys_in    (clk_sys_in),
		.rst_in        (rst_in),
		.in_valid_in   (byte_done && in_wdata),
		.in_ready_out  (buf_in_ready),
		.in_data_in    ({addr_reg, shift_reg}),
		.out_valid_out (buf_out_valid),
		.out_ready_in  (!rf_write_busy_in),
		.out_data_out  (buf_out_data)
	);

	always_ff @(posedge clk_sys_in)
	begin
		if (buf_out_valid && !rf_write_busy_in)
			mem[buf_out_data[AW+7:8]] <= buf_out_data[7:0];
	end

	// RF side status pins
	wire act_busy = mode_reg ? rf_cmd_busy_in : rf_write_busy_in;
	wire off_done = rf_field_off_in && (off_cnt_reg == OFF_LAST);

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			mode_reg <= eeprom_link_pkg::rf_write_indication_mode;
			act_oe_reg <= 1'b0;
			off_cnt_reg <= '0;
			rf_reset_reg <= 1'b0;
			eh_reg <= 1'b0;
		end
		else
		begin
			if (cfg_wr_in)
				mode_reg <= cfg_cmd_mode_in;
			act_oe_reg <= vcc_powered_in && act_busy;
			if (!rf_field_off_in)
				off_cnt_reg <= '0;
			else if (!off_done)
				off_cnt_reg <= off_cnt_reg + 1'b1;
			rf_reset_reg <= off_done;
			eh_reg <= eh_enable_in && rf_field_ok_in;
		end
	end

	assign bus.rf_activity_out = 1'b0;
	assign bus.rf_activity_oe = act_oe_reg;
	assign rf_reset_out = rf_reset_reg;
	assign eh_vout_enable_out = eh_reg;
	assign rf_command_indication_mode_out = mode_reg;
endmodule : eeprom_device_end

/* File: eeprom_host_end.sv */
`timescale 1ns/10ps
`include "eeprom_link_consts.svh"
module eeprom_host_end #(
	parameter logic [3:0] TYPE_ID     = `EE_TYPE_ID,
	parameter int         QUARTER_CYC = `EE_SCL_QUARTER_CYCLES
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_in,
	i2c_link_if.host                  bus,
	input  wire logic                 cmd_valid_in,
	output wire logic                 cmd_ready_out,
	input  wire logic                 cmd_read_in,
	input  wire logic [`EE_ADDR_W-1:0] cmd_addr_in,
	input  wire logic [7:0]           cmd_wdata_in,
	output wire logic                 rsp_valid_out,
	output wire logic [7:0]           rsp_data_out,
	output wire logic                 rsp_nack_out,
	output wire logic                 rf_activity_seen_out
);
	localparam int QW = $clog2(QUARTER_CYC + 1);
	localparam logic [QW-1:0] Q_LAST = QW'(QUARTER_CYC - 1);

	eeprom_link_pkg::host_state_t state_reg;
	eeprom_link_pkg::host_op_t    op;
	logic [QW-1:0]                div_reg;
	logic [1:0]                   q_reg;
	logic [2:0]                   step_reg;
	logic [3:0]                   bit_reg;
	logic                         read_reg;
	logic [15:0]                  addr_reg;
	logic [7:0]                   wdata_reg;
	logic [7:0]                   rx_reg;
	logic                         nack_reg;
	logic                         scl_reg;
	logic                         sda_rel_reg;
	logic                         rsp_valid_reg;
	logic [1:0]                   sda_sync_reg;
	logic [1:0]                   act_sync_reg;
	logic [7:0]                   tx_byte;

	wire tick = (state_reg == eeprom_link_pkg::h_run) && (div_reg == Q_LAST);
	wire [2:0] stop_step = read_reg ? 3'h7 : 3'h5;
	wire [7:0] sel_w = {TYPE_ID, `EE_SEL_LOW, 1'b0};

	// Step sequence; read adds a repeated Start
	assign op = (step_reg == 3'h0 || (read_reg && step_reg == 3'h4)) ? eeprom_link_pkg::op_start
		: (step_reg == stop_step) ? eeprom_link_pkg::op_stop
		: (read_reg && step_reg == 3'h6) ? eeprom_link_pkg::op_rx
		: eeprom_link_pkg::op_tx;
	assign tx_byte = (step_reg == 3'h1) ? sel_w
		: (step_reg == 3'h2) ? addr_reg[15:8]
		: (step_reg == 3'h3) ? addr_reg[7:0]
		: (step_reg == 3'h5) ? (sel_w | 8'h01)
		: wdata_reg;

	wire ack_bit = (bit_reg == 4'h8);
	// Single-byte read: last byte gets NoAck
	wire tx_rel = ack_bit || tx_byte[3'(4'h7 - bit_reg)];
	wire scl_want = (q_reg == 2'h1) || (q_reg == 2'h2) || (op == eeprom_link_pkg::op_stop && q_reg == 2'h3);
	wire sda_want = (op == eeprom_link_pkg::op_start) ? (q_reg < 2'h2)
		: (op == eeprom_link_pkg::op_stop) ? (q_reg > 2'h1)
		: (op == eeprom_link_pkg::op_tx) ? tx_rel
		: 1'b1;
	wire sample = tick && (q_reg == 2'h2);
	wire last_q = tick && (q_reg == 2'h3);
	wire op_end = last_q && ((op == eeprom_link_pkg::op_start) || (op == eeprom_link_pkg::op_stop) || ack_bit);

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			sda_sync_reg <= 2'h3;
			act_sync_reg <= 2'h3;
		end
		else
		begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda_line};
			act_sync_reg <= {act_sync_reg[0], bus.rf_activity_line};
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			state_reg <= eeprom_link_pkg::h_idle;
			div_reg <= '0;
			q_reg <= 2'h0;
			step_reg <= 3'h0;
			bit_reg <= 4'h0;
			rsp_valid_reg <= 1'b0;
		end
		else
		begin
			rsp_valid_reg <= 1'b0;
			if (cmd_valid_in && cmd_ready_out)
				state_reg <= eeprom_link_pkg::h_run;
			div_reg <= (tick || state_reg == eeprom_link_pkg::h_idle) ? '0 : div_reg + 1'b1;
			if (tick)
				q_reg <= q_reg + 2'h1;
			if (last_q && !op_end)
				bit_reg <= bit_reg + 4'h1;
			if (op_end)
			begin
				bit_reg <= 4'h0;
				if (op == eeprom_link_pkg::op_stop)
				begin
					state_reg <= eeprom_link_pkg::h_idle;
					step_reg <= 3'h0;
					rsp_valid_reg <= 1'b1;
				end
				else if (op == eeprom_link_pkg::op_tx && nack_reg)
					step_reg <= stop_step;
				else
					step_reg <= step_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			read_reg <= 1'b0;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			rx_reg <= 8'h00;
			nack_reg <= 1'b0;
			scl_reg <= 1'b1;
			sda_rel_reg <= 1'b1;
		end
		else
		begin
			if (cmd_valid_in && cmd_ready_out)
			begin
				read_reg <= cmd_read_in;
				addr_reg <= 16'(cmd_addr_in);
				wdata_reg <= cmd_wdata_in;
				nack_reg <= 1'b0;
			end
			if (sample && op == eeprom_link_pkg::op_tx && ack_bit)
				nack_reg <= sda_sync_reg[1];
			if (sample && op == eeprom_link_pkg::op_rx && !ack_bit)
				rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
			if (tick)
			begin
				scl_reg <= scl_want;
				sda_rel_reg <= sda_want;
			end
		end
	end

	assign bus.scl_line = scl_reg;
	assign bus.sda_host_out = 1'b0;
	assign bus.sda_host_oe = !sda_rel_reg;
	assign cmd_ready_out = (state_reg == eeprom_link_pkg::h_idle);
	assign rsp_valid_out = rsp_valid_reg;
	assign rsp_data_out = rx_reg;
	assign rsp_nack_out = nack_reg;
	assign rf_activity_seen_out = !act_sync_reg[1];
endmodule : eeprom_host_end

/* File: i2c_link_checker.sv */
`timescale 1ns/10ps
module i2c_link_checker (
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	input  wire logic scl_line,
	input  wire logic sda_host_oe,
	input  wire logic sda_dev_out,
	input  wire logic sda_dev_oe,
	input  wire logic sda_line,
	input  wire logic rf_activity_out,
	input  wire logic rf_activity_oe
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	property p_dev_low_only;
		sda_dev_oe |-> !sda_dev_out;
	endproperty
	a_dev_low_only: assert property (p_dev_low_only)
		else $error("device drives sda high");
	property p_act_low_only;
		rf_activity_oe |-> !rf_activity_out;
	endproperty
	a_act_low_only: assert property (p_act_low_only)
		else $error("activity pin driven high");
	property p_dev_moves_scl_low;
		$changed(sda_dev_oe) |-> !scl_line;
	endproperty
	a_dev_moves_scl_low: assert property (p_dev_moves_scl_low)
		else $error("device sda changed while scl high");
	property p_held_while_high;
		$rose(scl_line) && sda_dev_oe |-> sda_dev_oe[*8];
	endproperty
	a_held_while_high: assert property (p_held_while_high)
		else $error("device drive dropped during scl high");
	property p_release_bound;
		$rose(sda_dev_oe) |-> ##[1:150] !sda_dev_oe;
	endproperty
	a_release_bound: assert property (p_release_bound)
		else $error("device holds sda too long");
	property p_no_clash;
		scl_line && sda_dev_oe |-> !sda_host_oe;
	endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive sda");
	property p_start_by_host;
		scl_line && $past(scl_line) && $fell(sda_line) |-> sda_host_oe && !sda_dev_oe;
	endproperty
	a_start_by_host: assert property (p_start_by_host)
		else $error("start not made by host");
	property p_stop_by_host;
		scl_line && $past(scl_line) && $rose(sda_line) |-> !sda_dev_oe && $past(sda_host_oe);
	endproperty
	a_stop_by_host: assert property (p_stop_by_host)
		else $error("stop not made by host");
	property p_reset_release;
		$fell(rst_in) |-> !sda_dev_oe && !rf_activity_oe && scl_line;
	endproperty
	a_reset_release: assert property (p_reset_release)
		else $error("lines not released after reset");

	cover property ($rose(sda_dev_oe));
	cover property (scl_line && $fell(sda_line));
	cover property ($rose(rf_activity_oe));
endmodule : i2c_link_checker

/* File: tb.sv */
`timescale 1ns/10ps
`include "eeprom_link_consts.svh"
module tb;
	localparam int RF_OFF = 20;
	logic clk_sys_in, rst_in, cmd_valid_in, cmd_read_in, cfg_wr_in, cfg_cmd_mode_in, exp;
	logic vcc_powered_in, rf_write_busy_in, rf_cmd_busy_in, rf_field_off_in;
	logic eh_enable_in, rf_field_ok_in;
	logic      [`EE_ADDR_W-1:0] cmd_addr_in;
	logic      [7:0]            cmd_wdata_in;
	wire logic                  cmd_ready_out, rsp_valid_out, rsp_nack_out, rsp_nack_2;
	wire logic                  rf_activity_seen_out, rf_reset_out, eh_vout_enable_out;
	wire logic                  rf_command_indication_mode_out;
	wire logic [7:0]            rsp_data_out;
	int                         num_errors = 0, compares = 0, cycles = 0;

	i2c_link_if i_if ();
	i2c_link_if i_if_2 ();
	eeprom_host_end #(.QUARTER_CYC(4)) i_eeprom_host_end (.clk_sys_in, .rst_in, .bus(i_if),
		.cmd_valid_in, .cmd_ready_out, .cmd_read_in, .cmd_addr_in, .cmd_wdata_in, .rsp_valid_out,
		.rsp_data_out, .rsp_nack_out, .rf_activity_seen_out);
	eeprom_device_end #(.RF_OFF_CYCLES(RF_OFF)) i_eeprom_device_end (.clk_sys_in, .rst_in,
		.bus(i_if), .cfg_wr_in, .cfg_cmd_mode_in, .vcc_powered_in, .rf_write_busy_in,
		.rf_cmd_busy_in, .rf_field_off_in, .eh_enable_in, .rf_field_ok_in, .rf_reset_out,
		.eh_vout_enable_out, .rf_command_indication_mode_out);
	// Second link: host with a foreign type code
	eeprom_host_end #(.TYPE_ID(4'h9), .QUARTER_CYC(4)) i_eeprom_host_end_2 (.clk_sys_in,
		.rst_in, .bus(i_if_2), .cmd_valid_in, .cmd_ready_out(), .cmd_read_in, .cmd_addr_in,
		.cmd_wdata_in, .rsp_valid_out(), .rsp_data_out(), .rsp_nack_out(rsp_nack_2),
		.rf_activity_seen_out());
	eeprom_device_end #(.RF_OFF_CYCLES(RF_OFF)) i_eeprom_device_end_2 (.clk_sys_in, .rst_in,
		.bus(i_if_2), .cfg_wr_in, .cfg_cmd_mode_in, .vcc_powered_in, .rf_write_busy_in,
		.rf_cmd_busy_in, .rf_field_off_in, .eh_enable_in, .rf_field_ok_in, .rf_reset_out(),
		.eh_vout_enable_out(), .rf_command_indication_mode_out());
	i2c_link_checker i_i2c_link_checker (.clk_sys_in, .rst_in, .scl_line(i_if.scl_line),
		.sda_host_oe(i_if.sda_host_oe), .sda_dev_out(i_if.sda_dev_out),
		.sda_dev_oe(i_if.sda_dev_oe), .sda_line(i_if.sda_line),
		.rf_activity_out(i_if.rf_activity_out), .rf_activity_oe(i_if.rf_activity_oe));

	task automatic finish_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [7:0] want, input logic [7:0] got);
		compares++;
		if (got !== want)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, want, got);
		end
	endtask : check

	// One command on both links; the foreign link must always be refused
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d, input logic nk);
		int n;
		@(posedge clk_sys_in);
		cmd_valid_in <= 1'b1;
		cmd_read_in <= rd;
		cmd_addr_in <= a;
		cmd_wdata_in <= d;
		@(posedge clk_sys_in);
		while (cmd_ready_out !== 1'b1)
			@(posedge clk_sys_in);
		cmd_valid_in <= 1'b0;
		n = 0;
		while (rsp_valid_out !== 1'b1 && n < 2000)
		begin
			@(negedge clk_sys_in);
			n++;
		end
		check("rsp_valid", 8'h01, {7'h00, rsp_valid_out});
		check("rsp_nack", {7'h00, nk}, {7'h00, rsp_nack_out});
		if (rd)
			check("rsp_data", d, rsp_data_out);
		check("foreign nack", 8'h01, {7'h00, rsp_nack_2});
	endtask : xfer

	initial
	begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in)
	begin
		cycles++;
		if (!rst_in)
			check("foreign sda drive", 8'h00, {7'h00, i_if_2.sda_dev_oe});
		if (cycles >= 20000)
		begin
			num_errors++;
			finish_test();
		end
	end

	initial
	begin
		{rst_in, vcc_powered_in} = 2'h3;
		{cmd_valid_in, cmd_read_in, cfg_wr_in, cfg_cmd_mode_in, rf_write_busy_in} = 5'h00;
		{rf_cmd_busy_in, rf_field_off_in, eh_enable_in, rf_field_ok_in} = 4'h0;
		cmd_addr_in = 13'h0000;
		cmd_wdata_in = 8'h00;
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		check("idle lines", 8'h03, {6'h00, i_if.scl_line, i_if.sda_line});
		xfer(1'b0, 13'h0000, 8'ha5, 1'b0);
		xfer(1'b0, 13'h1fff, 8'h3c, 1'b0);
		xfer(1'b1, 13'h0000, 8'ha5, 1'b0);
		xfer(1'b1, 13'h1fff, 8'h3c, 1'b0);
		// Stalled drain: third word finds the buffer full
		@(posedge clk_sys_in) rf_write_busy_in <= 1'b1;
		xfer(1'b0, 13'h0006, 8'h44, 1'b0);
		xfer(1'b0, 13'h0007, 8'h55, 1'b0);
		xfer(1'b0, 13'h0000, 8'h99, 1'b1);
		@(posedge clk_sys_in) rf_write_busy_in <= 1'b0;
		repeat (20) @(posedge clk_sys_in);
		xfer(1'b1, 13'h0000, 8'ha5, 1'b0);
		xfer(1'b1, 13'h0006, 8'h44, 1'b0);
		xfer(1'b1, 13'h0007, 8'h55, 1'b0);
		// Field off: short, then long enough
		@(posedge clk_sys_in) rf_field_off_in <= 1'b1;
		repeat (RF_OFF - 5) @(posedge clk_sys_in);
		@(negedge clk_sys_in) check("rf_reset", 8'h00, {7'h00, rf_reset_out});
		repeat (10) @(posedge clk_sys_in);
		@(negedge clk_sys_in) check("rf_reset", 8'h01, {7'h00, rf_reset_out});
		@(posedge clk_sys_in) rf_field_off_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		@(negedge clk_sys_in) check("rf_reset", 8'h00, {7'h00, rf_reset_out});
		// Every mode, supply and busy combination
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk_sys_in);
			cfg_wr_in <= 1'b1;
			cfg_cmd_mode_in <= i[3];
			vcc_powered_in <= i[2];
			rf_write_busy_in <= i[1];
			rf_cmd_busy_in <= i[0];
			eh_enable_in <= i[1];
			rf_field_ok_in <= i[0];
			@(posedge clk_sys_in) cfg_wr_in <= 1'b0;
			repeat (5) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			exp = i[2] && (i[3] ? i[0] : i[1]);
			check("activity seen", {7'h00, exp}, {7'h00, rf_activity_seen_out});
			check("activity pin", {7'h00, !exp}, {7'h00, i_if.rf_activity_line});
			check("mode", {7'h00, i[3]}, {7'h00, rf_command_indication_mode_out});
			check("harvest", {7'h00, i[1] & i[0]}, {7'h00, eh_vout_enable_out});
		end
		finish_test();
	end
endmodule : tb
